// *** logic/idrt_idle_timer.sv ***
// Free-running idle down counter with a periodic tick.
// Assumes instr_tick pulses once per instruction cycle.
module idrt_idle_timer
  import idrt_pkg::*;
#(
  parameter int WIDTH = TIMER_WIDTH
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Time base
  input wire logic instr_tick,
  output logic idle_tick
);
  logic [WIDTH-1:0] idle_timer_reg;
  logic tap_prev_reg;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      idle_timer_reg <= '0;
    else if (instr_tick)
      idle_timer_reg <= idle_timer_reg - 1'b1;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      tap_prev_reg <= 1'b0;
    else
      tap_prev_reg <= idle_timer_reg[IDLE_TICK_BIT];
  end

  assign idle_tick = idle_timer_reg[IDLE_TICK_BIT] ^ tap_prev_reg;
endmodule : idrt_idle_timer

// *** logic/idrt_pin_edge.sv ***
// Pin synchroniser with rising and falling edge pulses.
// Assumes an asynchronous pin input; pulses are one sys_clk wide.
module idrt_pin_edge
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Pin and edges
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // ----------------------------------------
  // Two-stage synchroniser, then a history stage
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule : idrt_pin_edge

// *** logic/idrt_pkg.sv ***
// Constants shared by the idle and dual reload timer block.
// Assumes a 10 MHz system clock and a 1 us instruction cycle.
package idrt_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int INSTR_CYCLE_NS = 1000;
  localparam int INSTR_DIV = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int IDLE_TICK_BIT = 12;
  localparam int TIMER_WIDTH = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [7:0] IDX_AUX_ICTRL = 8'hE8;
  localparam logic [7:0] IDX_CONTROL = 8'hEE;
  localparam logic [7:0] IDX_STATUS = 8'hEF;
  localparam logic [7:0] IDX_HOLD_A = 8'hF0;
  localparam logic [7:0] IDX_HOLD_B = 8'hF1;
  localparam logic [7:0] IDX_COUNT = 8'hF2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_RUN_BIT = 4;
  localparam int CTL_MODE1_BIT = 5;
  localparam int CTL_MODE2_BIT = 6;
  localparam int CTL_MODE3_BIT = 7;
  localparam int STAT_ENA_BIT = 4;
  localparam int STAT_PNDA_BIT = 5;
  localparam int ICT_ENB_BIT = 0;
  localparam int ICT_PNDB_BIT = 1;
  localparam int ICT_IDLE_EN_BIT = 3;
  localparam int ICT_IDLE_PND_BIT = 4;

  typedef enum logic [1:0]
  {
    IDRT_EVENT = 2'b00,
    IDRT_PWM = 2'b01,
    IDRT_CAPTURE = 2'b10
  } idrt_mode_type;

  function automatic idrt_mode_type idrt_mode(input logic [2:0] sel);
    if (sel[1])
      return IDRT_CAPTURE;
    else if (sel[2])
      return IDRT_PWM;
    else
      return IDRT_EVENT;
  endfunction : idrt_mode

  // Merges write data into an old value under byte enables
  function automatic logic [15:0] idrt_merge(input logic [15:0] old_val,
    input logic [15:0] wdata, input logic [1:0] be);
    return {be[1] ? wdata[15:8] : old_val[15:8], be[0] ? wdata[7:0] : old_val[7:0]};
  endfunction : idrt_merge
endpackage : idrt_pkg

// *** logic/idrt_timer.sv ***
// Idle timer and general timer with two holding registers, Avalon-MM slave.
// Assumes sys_clk at 10 MHz and asynchronous pins on timer_pin_a/b.
module idrt_timer
  import idrt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timer pins
  input wire logic timer_pin_a_in,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe,
  input wire logic timer_pin_b,
  // Requests and time base
  output logic irq_idle,
  output logic irq_a,
  output logic irq_b,
  output logic idle_time_base
);
  logic [3:0] prescale_reg;
  logic instr_tick;
  logic idle_tick;
  logic [7:0] control_reg;
  logic enable_flag_a_reg;
  logic pending_flag_a_reg;
  logic enable_flag_b_reg;
  logic pending_flag_b_reg;
  logic idle_tick_enable_reg;
  logic idle_tick_pending_reg;
  logic [15:0] general_timer_reg;
  logic [15:0] holding_reg_a;
  logic [15:0] holding_reg_b;
  logic reload_b_next_reg;
  logic read_done_reg;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  idrt_mode_type mode;
  logic run;
  logic count_step;
  logic underflow;
  logic edge_a;
  logic edge_b;
  logic set_pnd_a;
  logic set_pnd_b;
  logic set_run;
  logic wr_ok;
  logic [7:0] wr_idx;
  logic [15:0] wr_data;

  // ----------------------------------------
  // Instruction cycle prescaler
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      prescale_reg <= 4'h0;
    else if (prescale_reg == 4'(INSTR_DIV - 1))
      prescale_reg <= 4'h0;
    else
      prescale_reg <= prescale_reg + 4'h1;
  end

  assign instr_tick = (prescale_reg == 4'(INSTR_DIV - 1));

  // No bus path to the idle count
  idrt_idle_timer u_idle
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .instr_tick(instr_tick),
    .idle_tick(idle_tick)
  );

  assign idle_time_base = idle_tick;

  idrt_pin_edge u_pin_a
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(timer_pin_a_in),
    .rise(a_rise),
    .fall(a_fall)
  );

  idrt_pin_edge u_pin_b
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(timer_pin_b),
    .rise(b_rise),
    .fall(b_fall)
  );

  // ----------------------------------------
  // Mode decode and count enable
  // ----------------------------------------
  assign mode = idrt_mode(control_reg[CTL_MODE3_BIT:CTL_MODE1_BIT]);
  assign run = control_reg[CTL_RUN_BIT];

  // Pin A falls when mode bit 1 set, pin B when bit 3 set in capture
  assign edge_a = control_reg[CTL_MODE1_BIT] ? a_fall : a_rise;
  assign edge_b = (mode == IDRT_CAPTURE && control_reg[CTL_MODE3_BIT]) ? b_fall : b_rise;

  always_comb
  begin
    case (mode)
      // Event clocked by pin A edge
      IDRT_EVENT: count_step = run & edge_a;
      // PWM clocked by instruction cycle; gated by run
      IDRT_PWM: count_step = run & instr_tick;
      IDRT_CAPTURE: count_step = instr_tick;
      default: count_step = 1'b0;
    endcase
  end

  assign underflow = count_step && (general_timer_reg == 16'h0000);

  always_comb
  begin
    case (mode)
      IDRT_PWM:
      begin
        set_pnd_a = underflow & ~reload_b_next_reg;
        set_pnd_b = underflow & reload_b_next_reg;
      end
      // Underflow to A, pin B rise to B
      IDRT_EVENT:
      begin
        set_pnd_a = underflow;
        set_pnd_b = b_rise;
      end
      // Capture edges to A and B
      IDRT_CAPTURE:
      begin
        set_pnd_a = edge_a;
        set_pnd_b = edge_b;
      end
      default:
      begin
        set_pnd_a = 1'b0;
        set_pnd_b = 1'b0;
      end
    endcase
  end

  // Capture underflow reuses the run bit
  assign set_run = (mode == IDRT_CAPTURE) && underflow;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wr_idx = address[9:2];
  assign wr_ok = write && (address[1:0] == 2'b00);
  assign wr_data = writedata[15:0];
  // Writes finish at once; reads take one wait cycle so read data is registered
  assign waitrequest = read & ~read_done_reg;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      read_done_reg <= 1'b0;
    else
      read_done_reg <= read & ~read_done_reg;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      readdata <= 32'h0000_0000;
    else if (read && !read_done_reg)
    begin
      readdata <= 32'h0000_0000;
      if (address[1:0] == 2'b00)
        case (wr_idx)
          IDX_CONTROL: readdata[7:0] <= control_reg;
          IDX_STATUS:
          begin
            readdata[STAT_PNDA_BIT] <= pending_flag_a_reg;
            readdata[STAT_ENA_BIT] <= enable_flag_a_reg;
          end
          IDX_AUX_ICTRL:
          begin
            readdata[ICT_ENB_BIT] <= enable_flag_b_reg;
            readdata[ICT_PNDB_BIT] <= pending_flag_b_reg;
            readdata[ICT_IDLE_EN_BIT] <= idle_tick_enable_reg;
            readdata[ICT_IDLE_PND_BIT] <= idle_tick_pending_reg;
          end
          IDX_HOLD_A: readdata[15:0] <= holding_reg_a;
          IDX_HOLD_B: readdata[15:0] <= holding_reg_b;
          IDX_COUNT: readdata[15:0] <= general_timer_reg;
          default: readdata <= 32'h0000_0000;
        endcase
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      control_reg <= CONTROL_RESET;
    else
    begin
      if (wr_ok && wr_idx == IDX_CONTROL && byteenable[0])
        control_reg <= writedata[7:0];
      // Underflow flag set wins over software write
      if (set_run)
        control_reg[CTL_RUN_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Enables and pending flags
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      enable_flag_a_reg <= 1'b0;
      enable_flag_b_reg <= 1'b0;
      idle_tick_enable_reg <= 1'b0;
    end
    else if (wr_ok && byteenable[0])
    begin
      if (wr_idx == IDX_STATUS)
        enable_flag_a_reg <= writedata[STAT_ENA_BIT];
      if (wr_idx == IDX_AUX_ICTRL)
      begin
        enable_flag_b_reg <= writedata[ICT_ENB_BIT];
        idle_tick_enable_reg <= writedata[ICT_IDLE_EN_BIT];
      end
    end
  end

  // Writing zero clears, writing one does nothing, set wins
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pending_flag_a_reg <= 1'b0;
      pending_flag_b_reg <= 1'b0;
      idle_tick_pending_reg <= 1'b0;
    end
    else
    begin
      if (set_pnd_a)
        pending_flag_a_reg <= 1'b1;
      else if (wr_ok && byteenable[0] && wr_idx == IDX_STATUS && !writedata[STAT_PNDA_BIT])
        pending_flag_a_reg <= 1'b0;
      if (set_pnd_b)
        pending_flag_b_reg <= 1'b1;
      else if (wr_ok && byteenable[0] && wr_idx == IDX_AUX_ICTRL && !writedata[ICT_PNDB_BIT])
        pending_flag_b_reg <= 1'b0;
      if (idle_tick)
        idle_tick_pending_reg <= 1'b1;
      else if (wr_ok && byteenable[0] && wr_idx == IDX_AUX_ICTRL
               && !writedata[ICT_IDLE_PND_BIT])
        idle_tick_pending_reg <= 1'b0;
    end
  end

  // Idle request gated by its enable
  assign irq_idle = idle_tick_pending_reg & idle_tick_enable_reg;
  // Run bit joins pending A in capture
  assign irq_a = enable_flag_a_reg & (pending_flag_a_reg | (mode == IDRT_CAPTURE && run));
  assign irq_b = enable_flag_b_reg & pending_flag_b_reg;

  // ----------------------------------------
  // General timer and holding registers
  // ----------------------------------------
  // Reset value is only for simulation; software must load before use
  // Counter with reload or capture targets
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      general_timer_reg <= COUNT_RESET;
    else if (wr_ok && wr_idx == IDX_COUNT)
      general_timer_reg <= idrt_merge(general_timer_reg, wr_data, byteenable[1:0]);
    else if (underflow && mode == IDRT_PWM)
      general_timer_reg <= reload_b_next_reg ? holding_reg_b : holding_reg_a;
    else if (underflow && mode == IDRT_EVENT)
      general_timer_reg <= holding_reg_a;
    else if (count_step)
      general_timer_reg <= general_timer_reg - 16'h0001;
  end

  // Capture copies count; capture wins over a same-cycle write
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      holding_reg_a <= COUNT_RESET;
      holding_reg_b <= COUNT_RESET;
    end
    else
    begin
      if (mode == IDRT_CAPTURE && edge_a)
        holding_reg_a <= general_timer_reg;
      else if (wr_ok && wr_idx == IDX_HOLD_A)
        holding_reg_a <= idrt_merge(holding_reg_a, wr_data, byteenable[1:0]);
      if (mode == IDRT_CAPTURE && edge_b)
        holding_reg_b <= general_timer_reg;
      else if (wr_ok && wr_idx == IDX_HOLD_B)
        holding_reg_b <= idrt_merge(holding_reg_b, wr_data, byteenable[1:0]);
    end
  end

  // Start from A after each start, then alternate
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reload_b_next_reg <= 1'b0;
    else if (!(run && mode == IDRT_PWM))
      reload_b_next_reg <= 1'b0;
    else if (underflow)
      reload_b_next_reg <= ~reload_b_next_reg;
  end

  // Pin A toggles in PWM with mode bit 1; never driven otherwise
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      timer_pin_a_out <= 1'b0;
    else if (mode == IDRT_PWM && control_reg[CTL_MODE1_BIT] && underflow)
      timer_pin_a_out <= ~timer_pin_a_out;
  end

  assign timer_pin_a_oe = (mode == IDRT_PWM) && control_reg[CTL_MODE1_BIT];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Clocks since the last instruction tick; zero until the first one, so start-up is not judged
  logic [4:0] tick_gap_reg;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      tick_gap_reg <= 5'h00;
    else if (instr_tick)
      tick_gap_reg <= 5'h01;
    else if (tick_gap_reg != 5'h00)
      tick_gap_reg <= tick_gap_reg + 5'h01;
  end

  sequence s_pwm_uf_a;
    mode == IDRT_PWM && underflow && !reload_b_next_reg && !(wr_ok && wr_idx == IDX_COUNT);
  endsequence

  sequence s_pwm_uf_b;
    mode == IDRT_PWM && underflow && reload_b_next_reg;
  endsequence

  a_idle_tick_latch: assert property (@(posedge sys_clk) disable iff (reset)
    idle_tick |=> idle_tick_pending_reg)
    else $error("idle tick not latched");
  a_idle_req_gate: assert property (@(posedge sys_clk) disable iff (reset)
    !idle_tick_enable_reg |-> !irq_idle)
    else $error("idle request while disabled");
  a_pwm_reload_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_pwm_uf_a |=> general_timer_reg == $past(holding_reg_a) && reload_b_next_reg)
    else $error("first reload not from A");
  a_pwm_flag_b: assert property (@(posedge sys_clk) disable iff (reset)
    s_pwm_uf_b |=> pending_flag_b_reg && !reload_b_next_reg)
    else $error("reload B did not set flag B");
  a_event_pin_free: assert property (@(posedge sys_clk) disable iff (reset)
    mode == IDRT_EVENT |-> !timer_pin_a_oe)
    else $error("pin A driven in event mode");
  a_capture_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
    mode == IDRT_CAPTURE && edge_a |=> holding_reg_a == $past(general_timer_reg))
    else $error("capture A missed");
  a_capture_uf_run: assert property (@(posedge sys_clk) disable iff (reset)
    set_run |=> run)
    else $error("capture underflow lost");
  a_stopped_holds: assert property (@(posedge sys_clk) disable iff (reset)
    mode != IDRT_CAPTURE && !run && !(wr_ok && wr_idx == IDX_COUNT)
    |=> general_timer_reg == $past(general_timer_reg))
    else $error("stopped timer moved");
  a_prescale_period: assert property (@(posedge sys_clk) disable iff (reset)
    tick_gap_reg != 5'h00
    |-> (instr_tick ? tick_gap_reg == 5'(INSTR_DIV) : tick_gap_reg < 5'(INSTR_DIV)))
    else $error("instruction cycle not ten clocks");
  a_set_wins_a: assert property (@(posedge sys_clk) disable iff (reset)
    set_pnd_a |=> pending_flag_a_reg)
    else $error("pending A set lost");
endmodule : idrt_timer

// *** tb/idrt_pin_source.sv ***
// Far-side model: signal sources on timer pins A and B.
// Assumes pin A is a shared line that the timer owns while its enable is high.
module idrt_pin_source
(
  // Clock
  input wire logic sys_clk,
  // Pin A line
  input wire logic pin_a_drv,
  input wire logic pin_a_oe,
  output logic pin_a_line,
  // Pin B line
  output logic pin_b_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic src_a = 1'b0;
  logic src_b = 1'b0;
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  // The source yields pin A to the timer so the two never fight
  assign pin_a_line = pin_a_oe ? pin_a_drv : src_a;
  assign pin_b_line = src_b;

  // Levels change just after a rising edge
  task automatic set_pins(input logic a, input logic b);
    @(posedge sys_clk);
    src_a <= a;
    src_b <= b;
  endtask : set_pins
endmodule : idrt_pin_source

// *** tb/idrt_timer_test.sv ***
// Self-checking bench for the idle and dual reload timer.
// Assumes the pin source model drives both timer pins.
module idrt_timer_test
  import idrt_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic pin_a_out;
  logic pin_a_oe;
  logic pin_a;
  logic pin_b;
  logic irq_idle;
  logic irq_a;
  logic irq_b;
  logic idle_time_base;
  logic [31:0] q;
  logic last_a = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int idle_q[$];
  int tog_q[$];

  always #50 sys_clk = ~sys_clk;

  idrt_timer i_dut (.sys_clk(sys_clk), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .timer_pin_a_in(pin_a), .timer_pin_a_out(pin_a_out),
    .timer_pin_a_oe(pin_a_oe), .timer_pin_b(pin_b), .irq_idle(irq_idle), .irq_a(irq_a),
    .irq_b(irq_b), .idle_time_base(idle_time_base));
  idrt_pin_source i_src (.sys_clk(sys_clk), .pin_a_drv(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_a_line(pin_a), .pin_b_line(pin_b));

  // ----------------------------------------
  // Event log: idle ticks and pin A toggles, in cycles
  // ----------------------------------------
  always @(negedge sys_clk)
  begin
    cyc++;
    if (idle_time_base === 1'b1)
      idle_q.push_back(cyc);
    if (pin_a_out !== last_a)
      tog_q.push_back(cyc);
    last_a = pin_a_out;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon transfer; held until waitrequest is seen low at a rising edge,
  // where read data is taken and the request released. Only the watchdog ends a hang.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
    @(posedge sys_clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0000, d};
    byteenable <= 4'h3;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 16'h0000);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic pulse_a(input int n);
    repeat (n)
    begin
      i_src.set_pins(1'b1, 1'b0);
      repeat (5) @(posedge sys_clk);
      i_src.set_pins(1'b0, 1'b0);
      repeat (5) @(posedge sys_clk);
    end
  endtask : pulse_a

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Whole run is about 41k cycles; the limit leaves margin but stays under 100k
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end

  initial
  begin
    int a;
    int b;
    int c;
    int k;
    int m;
    logic [7:0] ctl;
    logic [15:0] cap_a;
    a = $urandom(52);
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    // ----------------------------------------
    // Reset values, refused index, idle gating
    // ----------------------------------------
    rd(IDX_CONTROL);
    chk("control", q, 32'h0);
    rd(IDX_STATUS);
    chk("status", q, 32'h0);
    rd(8'hE9);
    chk("unmapped", q, 32'h0);
    wr(IDX_AUX_ICTRL, 16'h0018);
    rd(IDX_AUX_ICTRL);
    chk("idle pending", q, 32'h18);
    @(negedge sys_clk);
    chk("irq_idle on", irq_idle, 1'b1);
    wr(IDX_AUX_ICTRL, 16'h0010);
    @(negedge sys_clk);
    chk("irq_idle masked", irq_idle, 1'b0);
    wr(IDX_AUX_ICTRL, 16'h0008);
    rd(IDX_AUX_ICTRL);
    chk("idle cleared", q, 32'h08);
    $display("register test done");
    // ----------------------------------------
    // PWM: alternate reloads, toggles, flags
    // ----------------------------------------
    a = $urandom_range(6, 1);
    b = a + $urandom_range(4, 1);
    wr(IDX_HOLD_A, a[15:0]);
    wr(IDX_HOLD_B, b[15:0]);
    wr(IDX_COUNT, 16'h0000);
    wr(IDX_STATUS, 16'h0010);
    tog_q.delete();
    wr(IDX_CONTROL, 16'h00B0);
    k = 0;
    while (tog_q.size() < 4 && k < 3000)
    begin
      k++;
      @(posedge sys_clk);
    end
    for (m = 0; m < 3; m++)
      chk("pwm period", tog_q[m + 1] - tog_q[m], ((m % 2) ? b + 1 : a + 1) * INSTR_DIV);
    @(negedge sys_clk);
    chk("pin a oe", pin_a_oe, 1'b1);
    chk("irq_a pwm", irq_a, 1'b1);
    rd(IDX_AUX_ICTRL);
    chk("pwm pending b", q & 32'h2, 32'h2);
    wr(IDX_CONTROL, 16'h0080);
    @(negedge sys_clk);
    chk("pin a oe off", pin_a_oe, 1'b0);
    rd(IDX_COUNT);
    c = q;
    repeat (30) @(posedge sys_clk);
    rd(IDX_COUNT);
    chk("stopped count", q, c);
    wr(IDX_STATUS, 16'h0030);
    rd(IDX_STATUS);
    chk("pending kept", q, 32'h30);
    wr(IDX_STATUS, 16'h0010);
    rd(IDX_STATUS);
    chk("pending cleared", q, 32'h10);
    k = tog_q.size();
    wr(IDX_CONTROL, 16'h0090);
    repeat (200) @(posedge sys_clk);
    chk("no toggle", tog_q.size(), k);
    $display("pwm test done");
    // ----------------------------------------
    // Event counting on both edge choices
    // ----------------------------------------
    for (m = 0; m < 2; m++)
    begin
      c = $urandom_range(4, 1);
      wr(IDX_CONTROL, 16'h0000);
      wr(IDX_HOLD_A, 16'h0007);
      wr(IDX_COUNT, c[15:0]);
      wr(IDX_STATUS, 16'h0000);
      wr(IDX_CONTROL, m ? 16'h0030 : 16'h0010);
      pulse_a(c);
      rd(IDX_COUNT);
      chk("event count", q, 32'h0);
      pulse_a(1);
      rd(IDX_COUNT);
      chk("event reload", q, 32'h7);
      rd(IDX_STATUS);
      chk("event pending a", q, 32'h20);
      chk("event oe", pin_a_oe, 1'b0);
    end
    wr(IDX_AUX_ICTRL, 16'h0001);
    i_src.set_pins(1'b0, 1'b1);
    repeat (5) @(posedge sys_clk);
    i_src.set_pins(1'b0, 1'b0);
    rd(IDX_AUX_ICTRL);
    chk("event pending b", q, 32'h3);
    @(negedge sys_clk);
    chk("irq_b", irq_b, 1'b1);
    wr(IDX_CONTROL, 16'h0000);
    rd(IDX_COUNT);
    c = q;
    pulse_a(2);
    rd(IDX_COUNT);
    chk("event stopped", q, c);
    $display("event test done");
    // ----------------------------------------
    // Capture on all four polarity pairs
    // ----------------------------------------
    for (m = 0; m < 4; m++)
    begin
      ctl = {m[0], 1'b1, m[1], 5'h00};
      i_src.set_pins(m[1], m[0]);
      wr(IDX_CONTROL, {8'h00, ctl});
      wr(IDX_STATUS, 16'h0000);
      wr(IDX_AUX_ICTRL, 16'h0000);
      k = $urandom_range(30, 5);
      i_src.set_pins(~m[1], m[0]);
      repeat (k * INSTR_DIV - 1) @(posedge sys_clk);
      i_src.set_pins(~m[1], ~m[0]);
      repeat (10) @(posedge sys_clk);
      rd(IDX_HOLD_A);
      cap_a = q[15:0];
      rd(IDX_HOLD_B);
      chk("capture gap", {16'h0000, cap_a - q[15:0]}, k);
      rd(IDX_STATUS);
      chk("capture pending a", q, 32'h20);
      rd(IDX_AUX_ICTRL);
      chk("capture pending b", q, 32'h2);
      i_src.set_pins(m[1], m[0]);
      repeat (10) @(posedge sys_clk);
      rd(IDX_HOLD_A);
      chk("wrong edge ignored", q, {16'h0000, cap_a});
    end
    wr(IDX_CONTROL, 16'h0040);
    wr(IDX_STATUS, 16'h0010);
    wr(IDX_COUNT, 16'h0001);
    repeat (40) @(posedge sys_clk);
    rd(IDX_CONTROL);
    chk("underflow run bit", q, 32'h50);
    @(negedge sys_clk);
    chk("irq_a underflow", irq_a, 1'b1);
    wr(IDX_CONTROL, 16'h0040);
    @(negedge sys_clk);
    chk("irq_a cleared", irq_a, 1'b0);
    $display("capture test done");
    // ----------------------------------------
    // Idle tick spacing, 4096 instruction cycles
    // ----------------------------------------
    wr(IDX_AUX_ICTRL, 16'h0008);
    k = 0;
    while (idle_q.size() < 2 && k < 60000)
    begin
      k++;
      @(posedge sys_clk);
    end
    chk("idle spacing", idle_q[1] - idle_q[0], 4096 * INSTR_DIV);
    @(negedge sys_clk);
    chk("irq_idle again", irq_idle, 1'b1);
    $display("idle test done");
    wrap_up();
  end
endmodule : idrt_timer_test
